// file: rsc_pkg.sv
// Purpose: shared constants and types of the refresh/sleep config block
// Assumes: core clock 100 MHz, host bus clock asynchronous to it
// Notes:   the overview list below is the behaviour reference for the block
//
// Overview of operation
// - bit 6 selects single-ended or differential clock
// - single-ended mode ignores the complement clock input
// - writing 1 to bit 5 enters retention sleep
// - chip select low wakes, clears sleep bit
// - any reset ends sleep, refresh stops
// - bits 4:2 restrict self-refresh to a region
// - refresh only starts while the core sees no memory access
// - refresh busy at start drives strobe high
// - bits 1:0 report refresh interval by temperature
// - zero-latency writes drive strobe in CA only
// - zero-latency writes ignore the byte mask
// - fixed latency bit forces strobe high in CA
package rsc_pkg;
	// ************************************************
	// timing
	// ************************************************
	localparam int        CLK_PERIOD_NS  = 10;
	localparam int        REF_COOL_NS    = 4000;  // interval at or below 85 C
	localparam int        REF_HOT_NS     = 1000;  // interval up to 105 C
	localparam logic [11:0] REF_COOL_CYC = 12'(REF_COOL_NS / CLK_PERIOD_NS);
	localparam logic [11:0] REF_HOT_CYC  = 12'(REF_HOT_NS / CLK_PERIOD_NS);
	localparam logic [3:0]  REF_RUN_CYC  = 4'h8;  // cycles one row refresh takes
	localparam int        ROW_BITS       = 13;
	// ************************************************
	// register fields and values
	// ************************************************
	localparam int          CFG_RSV_LSB    = 7;
	localparam int          CFG_CLK_BIT    = 6;
	localparam int          CFG_SLEEP_BIT  = 5;
	localparam int          CFG_REGION_LSB = 2;
	localparam logic [15:0] CFG_RESET      = 16'hFFC1;
	localparam logic [8:0]  CFG_RSV_ONES   = 9'h1FF;
	localparam logic [1:0]  INTV_COOL      = 2'h1;
	localparam logic [1:0]  INTV_HOT       = 2'h2;
	localparam logic [2:0]  REGION_NONE    = 3'h4;
	// ************************************************
	// command-address word 0 fields
	// ************************************************
	localparam int CA_READ_BIT = 15;
	localparam int CA_REG_BIT  = 14;

	typedef struct packed {
		logic [8:0] reserved;   // always ones
		logic       clkSingle;  // 1 single-ended clock
		logic       sleep;      // retention sleep request
		logic [2:0] region;     // partial array refresh select
		logic [1:0] interval;   // read-only refresh interval code
	} rsc_cfg_t;

	typedef enum logic [1:0] {
		LNK_CA0  = 2'b00,
		LNK_CA1  = 2'b01,
		LNK_CA2  = 2'b10,
		LNK_DATA = 2'b11
	} rsc_link_state_t;

	typedef enum logic [1:0] {
		REF_IDLE = 2'b00,
		REF_WAIT = 2'b01,
		REF_RUN  = 2'b10
	} rsc_ref_state_t;
endpackage : rsc_pkg

// file: rsc_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: d is a slow level or a toggle
// Notes:   only q may be read by other logic
`timescale 1ns/1ps
module rsc_sync
#(
	parameter logic RST = 1'b0
)
(
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// data
	input  wire logic d,
	output logic      q
);
	logic meta_ff;  // first stage, read only by q

	// ************************************************
	// two stages, constant reset
	// ************************************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_ff <= RST;
			q       <= RST;
		end
		else
		begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule : rsc_sync

// file: rsc_link.sv
// Purpose: host bus front end on the bus clock
// Assumes: bus clock keeps running between frames so the crossings stay fresh
// Notes:   frame state is cleared by chip select going high
`timescale 1ns/1ps
module rsc_link
(
	// clocks and reset
	input  wire logic        busClk,
	input  wire logic        resetn,
	// bus pins
	input  wire logic        csN,
	input  wire logic [15:0] dqIn,
	output logic      [15:0] dqOut,
	output logic             dqOe,
	output logic      [1:0]  strobeMaskOut,
	output logic             strobeMaskOe,
	// from core domain
	input  wire logic        fixedLatency,
	input  wire logic        refreshBusy,
	input  wire logic        cfgTgl,
	input  wire logic [15:0] cfgWord,
	// to core domain
	output logic             accessActive,
	output logic             wrTgl,
	output logic      [15:0] wrWord
);
	logic [2:0]             syncIn;       // raw core levels
	logic [2:0]             syncOut;      // synchronised levels
	logic                   frameRstN;    // reset or deselect
	rsc_pkg::rsc_link_state_t state_ff, nxt_state;
	logic                   isRead_ff, nxt_isRead;
	logic                   isReg_ff, nxt_isReg;
	logic                   wrDone_ff, nxt_wrDone;
	logic                   extra;        // extra latency at frame start
	logic                   wrTake;       // register word arrives
	logic                   cfgSeen_ff, nxt_cfgSeen;
	logic [15:0]            cfgLocal_ff, nxt_cfgLocal;
	logic                   nxt_wrTgl;
	logic [15:0]            nxt_wrWord;
	logic [15:0]            nxt_dqOut;
	logic                   nxt_dqOe, nxt_strobeOe, nxt_access;
	logic [1:0]             nxt_strobe;

	// ************************************************
	// crossings from the core clock
	// ************************************************
	assign syncIn = {cfgTgl, refreshBusy, fixedLatency};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			rsc_sync u_sync (
				.clk    (busClk),
				.resetn (resetn),
				.d      (syncIn[gi]),
				.q      (syncOut[gi])
			);
		end
	endgenerate

	// deselect ends the frame even though the bus clock has stopped
	assign frameRstN = resetn & ~csN;
	// limitation: latency status is two bus clocks old; a stopped clock leaves it stale
	assign extra     = syncOut[0] | syncOut[1];
	assign wrTake    = (state_ff == rsc_pkg::LNK_DATA) & isReg_ff & ~isRead_ff & ~wrDone_ff;

	// ************************************************
	// frame sequencing
	// ************************************************
	always_comb
	begin
		nxt_state    = state_ff;
		nxt_isRead   = isRead_ff;
		nxt_isReg    = isReg_ff;
		nxt_wrDone   = wrDone_ff | wrTake;
		nxt_dqOut    = dqOut;
		nxt_dqOe     = dqOe;
		nxt_strobe   = strobeMaskOut;
		nxt_strobeOe = strobeMaskOe;
		nxt_access   = accessActive;
		unique case (state_ff)
			rsc_pkg::LNK_CA0:
			begin
				// decode and flag extra latency for the rest of CA
				nxt_isRead   = dqIn[rsc_pkg::CA_READ_BIT];
				nxt_isReg    = dqIn[rsc_pkg::CA_REG_BIT];
				nxt_strobe   = {2{extra}};
				nxt_strobeOe = 1'b1;
				nxt_access   = ~dqIn[rsc_pkg::CA_REG_BIT];
				nxt_state    = rsc_pkg::LNK_CA1;
			end
			rsc_pkg::LNK_CA1:
				nxt_state = rsc_pkg::LNK_CA2;
			rsc_pkg::LNK_CA2:
			begin
				// strobe released after CA; only register reads use dq
				nxt_strobeOe = 1'b0;
				nxt_dqOe     = isReg_ff & isRead_ff;
				nxt_dqOut    = cfgLocal_ff;
				nxt_state    = rsc_pkg::LNK_DATA;
			end
			rsc_pkg::LNK_DATA:
				nxt_state = rsc_pkg::LNK_DATA;
		endcase
	end

	always_ff @(posedge busClk or negedge frameRstN)
	begin
		if (!frameRstN)
		begin
			state_ff      <= rsc_pkg::LNK_CA0;
			isRead_ff     <= 1'b0;
			isReg_ff      <= 1'b0;
			wrDone_ff     <= 1'b0;
			dqOut         <= 16'h0000;
			dqOe          <= 1'b0;
			strobeMaskOut <= 2'h0;
			strobeMaskOe  <= 1'b0;
			accessActive  <= 1'b0;
		end
		else
		begin
			state_ff      <= nxt_state;
			isRead_ff     <= nxt_isRead;
			isReg_ff      <= nxt_isReg;
			wrDone_ff     <= nxt_wrDone;
			dqOut         <= nxt_dqOut;
			dqOe          <= nxt_dqOe;
			strobeMaskOut <= nxt_strobe;
			strobeMaskOe  <= nxt_strobeOe;
			accessActive  <= nxt_access;
		end
	end

	// ************************************************
	// handshake words, kept across frames
	// ************************************************
	always_comb
	begin
		// whole word taken, mask never consulted
		nxt_wrWord   = wrTake ? dqIn : wrWord;
		nxt_wrTgl    = wrTgl ^ wrTake;
		nxt_cfgSeen  = syncOut[2];
		nxt_cfgLocal = (syncOut[2] != cfgSeen_ff) ? cfgWord : cfgLocal_ff;
	end

	always_ff @(posedge busClk or negedge resetn)
	begin
		if (!resetn)
		begin
			wrWord      <= 16'h0000;
			wrTgl       <= 1'b0;
			cfgSeen_ff  <= 1'b0;
			cfgLocal_ff <= rsc_pkg::CFG_RESET;
		end
		else
		begin
			wrWord      <= nxt_wrWord;
			wrTgl       <= nxt_wrTgl;
			cfgSeen_ff  <= nxt_cfgSeen;
			cfgLocal_ff <= nxt_cfgLocal;
		end
	end

	AST_FIXED_STROBE: assert property (@(posedge busClk) disable iff (!frameRstN)
		(state_ff == rsc_pkg::LNK_CA1 && $past(syncOut[0])) |-> strobeMaskOe && strobeMaskOut == 2'h3)
		else $error("fixed latency strobe not high in CA");
	AST_REGWR_RELEASE: assert property (@(posedge busClk) disable iff (!frameRstN)
		(state_ff == rsc_pkg::LNK_DATA && isReg_ff && !isRead_ff) |-> !strobeMaskOe)
		else $error("strobe still driven during register write data");
	AST_WORD_WHOLE: assert property (@(posedge busClk) disable iff (!frameRstN)
		wrTake |=> wrWord == $past(dqIn))
		else $error("register write word not taken whole");
endmodule : rsc_link

// file: rsc_top.sv
// Purpose: refresh/sleep configuration register, self-refresh scheduler
// Assumes: host bus clock busClk, core clock clk, both reset by resetn
// Notes:   register written only through zero-latency bus writes
`timescale 1ns/1ps
module rsc_top
(
	// core clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// host bus
	input  wire logic        busClk,
	input  wire logic        csN,
	input  wire logic        clockComplement,
	input  wire logic [15:0] dqIn,
	output logic      [15:0] dqOut,
	output logic             dqOe,
	output logic      [1:0]  strobeMaskOut,
	output logic             strobeMaskOe,
	// device side levels
	input  wire logic        tempHot,
	input  wire logic        fixedLatency,
	// status
	output logic             clockDiffSel,
	output logic             clockComplementSeen,
	output logic             retentionSleep,
	output logic             refreshActive,
	output logic [12:0]      refreshRow
);
	rsc_pkg::rsc_cfg_t      cfg_ff, nxt_cfg;      // register image
	logic [15:0]            cfgXfer_ff, nxt_cfgXfer;  // word held for the link
	logic                   cfgTgl_ff, nxt_cfgTgl;
	rsc_pkg::rsc_ref_state_t refState_ff, nxt_refState;
	logic [11:0]            timer_ff, nxt_timer;  // counts to next slot
	logic [3:0]             runCnt_ff, nxt_runCnt;
	logic [12:0]            nxt_row;
	logic                   nxt_refreshActive;
	logic                   csPrev_ff;            // for chip select fall
	logic                   nxt_clockDiffSel, nxt_compSeen, nxt_sleepOut;
	// crossed levels
	logic                   csSync, hotSync, compSync, wrTglSync, accessSync;
	logic                   wrTglSeen_ff;
	// link side
	logic                   accessActive, wrTgl;
	logic [15:0]            wrWord;
	logic                   wrEvent, csFall, refStart;

	// ************************************************
	// region decode
	// ************************************************
	function automatic logic rowInRegion(input logic [2:0] region, input logic [2:0] top);
		logic hit;
		hit = 1'b1;
		unique case (region)
			3'h0: hit = 1'b1;
			3'h1: hit = (top[2] == 1'b0);
			3'h2: hit = (top[2:1] == 2'h0);
			3'h3: hit = (top == 3'h0);
			3'h4: hit = 1'b0;
			3'h5: hit = (top[2] == 1'b1);
			3'h6: hit = (top[2:1] == 2'h3);
			3'h7: hit = (top == 3'h7);
		endcase
		return hit;
	endfunction : rowInRegion

	// ************************************************
	// link front end and crossings
	// ************************************************
	rsc_link u_link (
		.busClk        (busClk),
		.resetn        (resetn),
		.csN           (csN),
		.dqIn          (dqIn),
		.dqOut         (dqOut),
		.dqOe          (dqOe),
		.strobeMaskOut (strobeMaskOut),
		.strobeMaskOe  (strobeMaskOe),
		.fixedLatency  (fixedLatency),
		.refreshBusy   (refreshActive),
		.cfgTgl        (cfgTgl_ff),
		.cfgWord       (cfgXfer_ff),
		.accessActive  (accessActive),
		.wrTgl         (wrTgl),
		.wrWord        (wrWord)
	);

	// chip select idles high, so its synchroniser resets high
	rsc_sync #(.RST(1'b1)) u_csSync (
		.clk    (clk),
		.resetn (resetn),
		.d      (csN),
		.q      (csSync)
	);

	logic [3:0] rawIn;   // other slow levels into the core
	logic [3:0] syncLv;  // and their synchronised copies
	assign rawIn = {accessActive, wrTgl, clockComplement, tempHot};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			rsc_sync u_sync (
				.clk    (clk),
				.resetn (resetn),
				.d      (rawIn[gi]),
				.q      (syncLv[gi])
			);
		end
	endgenerate
	assign hotSync    = syncLv[0];
	assign compSync   = syncLv[1];
	assign wrTglSync  = syncLv[2];
	assign accessSync = syncLv[3];

	// word is stable long before its toggle arrives here
	assign wrEvent = wrTglSync ^ wrTglSeen_ff;
	assign csFall  = csPrev_ff & ~csSync;

	// ************************************************
	// configuration register
	// ************************************************
	always_comb
	begin
		nxt_cfg          = cfg_ff;
		nxt_cfg.reserved = rsc_pkg::CFG_RSV_ONES;
		// interval tracks temperature, never the write data
		nxt_cfg.interval = hotSync ? rsc_pkg::INTV_HOT : rsc_pkg::INTV_COOL;
		// wake on select fall while sleeping
		if (csFall && cfg_ff.sleep)
		begin
			nxt_cfg.sleep = 1'b0;
		end
		// a write in the same cycle wins over the wake clear
		if (wrEvent)
		begin
			nxt_cfg.clkSingle = wrWord[rsc_pkg::CFG_CLK_BIT];
			nxt_cfg.sleep     = wrWord[rsc_pkg::CFG_SLEEP_BIT];
			nxt_cfg.region    = wrWord[rsc_pkg::CFG_REGION_LSB +: 3];
		end
		// republish the image to the link when it changes
		nxt_cfgTgl  = cfgTgl_ff ^ (nxt_cfg != cfg_ff);
		nxt_cfgXfer = (nxt_cfg != cfg_ff) ? 16'(nxt_cfg) : cfgXfer_ff;
		// complement clock is dropped in single-ended mode
		nxt_clockDiffSel = ~cfg_ff.clkSingle;
		nxt_compSeen     = ~cfg_ff.clkSingle & compSync;
		nxt_sleepOut     = cfg_ff.sleep;
	end

	// any reset lands here with sleep cleared
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg_ff              <= rsc_pkg::rsc_cfg_t'(rsc_pkg::CFG_RESET);
			cfgXfer_ff          <= rsc_pkg::CFG_RESET;
			cfgTgl_ff           <= 1'b0;
			wrTglSeen_ff        <= 1'b0;
			csPrev_ff           <= 1'b1;
			clockDiffSel        <= 1'b0;
			clockComplementSeen <= 1'b0;
			retentionSleep      <= 1'b0;
		end
		else
		begin
			cfg_ff              <= nxt_cfg;
			cfgXfer_ff          <= nxt_cfgXfer;
			cfgTgl_ff           <= nxt_cfgTgl;
			wrTglSeen_ff        <= wrTglSync;
			csPrev_ff           <= csSync;
			clockDiffSel        <= nxt_clockDiffSel;
			clockComplementSeen <= nxt_compSeen;
			retentionSleep      <= nxt_sleepOut;
		end
	end

	// ************************************************
	// distributed self-refresh
	// ************************************************
	always_comb
	begin
		nxt_refState = refState_ff;
		nxt_timer    = timer_ff - 12'h001;
		nxt_runCnt   = runCnt_ff;
		nxt_row      = refreshRow;
		refStart     = 1'b0;
		// slot every interval; hot parts get the shorter one
		if (timer_ff == 12'h000)
		begin
			nxt_timer = hotSync ? rsc_pkg::REF_HOT_CYC - 12'h001 : rsc_pkg::REF_COOL_CYC - 12'h001;
		end
		unique case (refState_ff)
			rsc_pkg::REF_IDLE:
			begin
				if (timer_ff == 12'h000)
				begin
					nxt_refState = rsc_pkg::REF_WAIT;
				end
			end
			rsc_pkg::REF_WAIT:
			begin
				// rows outside the region are skipped without a busy period
				if (!rowInRegion(cfg_ff.region, refreshRow[12:10]))
				begin
					nxt_row      = refreshRow + 13'h0001;
					nxt_refState = rsc_pkg::REF_IDLE;
				end
				else if (!accessSync)
				begin
					refStart     = 1'b1;
					nxt_runCnt   = rsc_pkg::REF_RUN_CYC - 4'h1;
					nxt_refState = rsc_pkg::REF_RUN;
				end
			end
			rsc_pkg::REF_RUN:
			begin
				nxt_runCnt = runCnt_ff - 4'h1;
				if (runCnt_ff == 4'h0)
				begin
					nxt_row      = refreshRow + 13'h0001;
					nxt_refState = rsc_pkg::REF_IDLE;
				end
			end
			default:
				nxt_refState = rsc_pkg::REF_IDLE;
		endcase
		// busy level reaches the link and raises the strobe
		nxt_refreshActive = (nxt_refState == rsc_pkg::REF_RUN);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			refState_ff   <= rsc_pkg::REF_IDLE;
			timer_ff      <= rsc_pkg::REF_COOL_CYC - 12'h001;
			runCnt_ff     <= 4'h0;
			refreshRow    <= 13'h0000;
			refreshActive <= 1'b0;
		end
		else
		begin
			refState_ff   <= nxt_refState;
			timer_ff      <= nxt_timer;
			runCnt_ff     <= nxt_runCnt;
			refreshRow    <= nxt_row;
			refreshActive <= nxt_refreshActive;
		end
	end

	// ************************************************
	// checks
	// ************************************************
	AST_WAKE_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
		(csFall && cfg_ff.sleep && !wrEvent) |=> !cfg_ff.sleep ##1 !retentionSleep)
		else $error("sleep not cleared after select fall");
	AST_SLEEP_SET: assert property (@(posedge clk) disable iff (!resetn)
		(wrEvent && wrWord[5]) |=> cfg_ff.sleep ##1 retentionSleep)
		else $error("sleep write not applied");
	AST_RO_IGNORED: assert property (@(posedge clk) disable iff (!resetn)
		wrEvent |=> cfg_ff.interval == ($past(hotSync) ? 2'h2 : 2'h1) && cfg_ff.reserved == 9'h1FF)
		else $error("read-only bits changed by write");
	AST_INTERVAL_TEMP: assert property (@(posedge clk) disable iff (!resetn)
		hotSync [*2] |-> cfg_ff.interval == 2'h2)
		else $error("interval code does not follow temperature");
	AST_CLK_SELECT: assert property (@(posedge clk) disable iff (!resetn)
		$changed(cfg_ff.clkSingle) |=> clockDiffSel == !$past(cfg_ff.clkSingle))
		else $error("clock select output wrong");
	AST_COMP_IGNORED: assert property (@(posedge clk) disable iff (!resetn)
		cfg_ff.clkSingle |=> !clockComplementSeen)
		else $error("complement clock seen in single-ended mode");
	AST_NO_ACCESS_REFRESH: assert property (@(posedge clk) disable iff (!resetn)
		refStart |-> !accessSync ##1 refreshActive)
		else $error("refresh started during host access");
	AST_REFRESH_LEN: assert property (@(posedge clk) disable iff (!resetn)
		$rose(refreshActive) |-> refreshActive [*8] ##1 !refreshActive)
		else $error("refresh busy period not eight cycles");
	AST_REGION_ONLY: assert property (@(posedge clk) disable iff (!resetn)
		refStart |-> cfg_ff.region != 3'h4 && rowInRegion(cfg_ff.region, refreshRow[12:10]))
		else $error("refresh outside selected region");
	AST_SLOT_BOUND: assert property (@(posedge clk) disable iff (!resetn)
		timer_ff < 12'd400)
		else $error("refresh slot timer beyond cool interval");
endmodule : rsc_top

// file: rsc_host_model.sv
// Purpose: host controller model driving the bus side of the config block
// Assumes: bus clock period 30 ns, free running, its level is don't care while deselected
// Notes:   frames are single data rate, one word per rising edge
`timescale 1ns/1ps
module rsc_host_model
(
	// from device
	input  wire logic        strobeMaskOe,
	input  wire logic [1:0]  strobeMaskOut,
	input  wire logic [15:0] dqOut,
	// to device
	output logic             busClk,
	output logic             clockComplement,
	output logic             csN,
	output logic      [15:0] dqIn
);
	// ************************************************
	// pins
	// ************************************************
	// complement always driven, never left floating
	assign clockComplement = ~busClk;
	// bus clock offset from the core clock so their edges never meet
	initial
	begin
		busClk = 1'b0;
		#7;
		forever #15 busClk = ~busClk;
	end
	initial
	begin
		csN    = 1'b1;
		dqIn   = 16'h0000;
	end
	// ************************************************
	// one frame: three CA words, then n+1 data edges
	// ************************************************
	// strobe lines are only sampled, never driven by the host
	task automatic frame(input logic [15:0] ca, input logic [15:0] wd, input int n,
		output logic [15:0] rd, output logic [1:0] sm, output logic oeLate);
		// pins change on the falling edge, half a period from sampling
		@(negedge busClk);
		csN  = 1'b0;
		dqIn = ca;
		@(negedge busClk);
		sm = strobeMaskOe ? strobeMaskOut : 2'h1;
		repeat (2) @(negedge busClk);
		oeLate = strobeMaskOe;
		dqIn   = wd;
		// callers keep n small enough to end before the select-low limit
		repeat (n + 1) @(negedge busClk);
		rd  = dqOut;
		csN = 1'b1;
		// released bus: inverse of last value so stale data never matches
		dqIn = ~dqIn;
	endtask : frame
	// wake pulse, bus clock left running, within 60 to 3000 ns
	task automatic wake();
		@(negedge busClk);
		csN = 1'b0;
		#90 csN = 1'b1;
		#30;
	endtask : wake
endmodule : rsc_host_model

// file: rsc_top_tb_top.sv
// Purpose: self-checking bench of the refresh/sleep config block
// Assumes: core clock 100 MHz, bus clock made by the host model
// Notes:   every register write keeps ones in the reserved bits
`timescale 1ns/1ps
module rsc_top_tb_top;
	// ************************************************
	// signals
	// ************************************************
	logic        clk, resetn, tempHot, fixedLatency, busClk, csN, clockComplement;
	logic [15:0] dqIn, dqOut, rd;
	logic        dqOe, strobeMaskOe, clockDiffSel, clockComplementSeen;
	logic        retentionSleep, refreshActive, mon, oeLate, got;
	logic [1:0]  strobeMaskOut, sm;
	int          badCount, nCompared, cycles, refDuring;
	// ************************************************
	// instances
	// ************************************************
	rsc_top i_dut (.clk(clk), .resetn(resetn), .busClk(busClk), .csN(csN),
		.clockComplement(clockComplement), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
		.strobeMaskOut(strobeMaskOut), .strobeMaskOe(strobeMaskOe), .tempHot(tempHot),
		.fixedLatency(fixedLatency), .clockDiffSel(clockDiffSel),
		.clockComplementSeen(clockComplementSeen), .retentionSleep(retentionSleep),
		.refreshActive(refreshActive), .refreshRow());
	rsc_host_model i_host (.strobeMaskOe(strobeMaskOe), .strobeMaskOut(strobeMaskOut),
		.dqOut(dqOut), .busClk(busClk), .clockComplement(clockComplement), .csN(csN),
		.dqIn(dqIn));
	// ************************************************
	// clock, timeout, refresh monitor
	// ************************************************
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// a hang counts as a mismatch and closes the run
	always @(posedge clk)
	begin
		cycles++;
		if (mon && refreshActive)
			refDuring++;
		if (cycles == 30000)
		begin
			badCount++;
			test_done();
		end
	end
	// ************************************************
	// tasks
	// ************************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			badCount++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// write then leave room for the handshake to settle
	task automatic wr(input logic [15:0] d);
		i_host.frame(16'h4000, d, 0, rd, sm, oeLate);
		repeat (12) @(posedge clk);
	endtask : wr
	task automatic rdc(input logic [15:0] exp);
		i_host.frame(16'hC000, 16'h0000, 0, rd, sm, oeLate);
		chk(rd, exp);
		repeat (8) @(posedge clk);
	endtask : rdc
	// bounded wait for refreshActive to reach a level
	task automatic waitRef(input logic lvl, input int lim);
		got = 1'b0;
		repeat (lim)
		begin
			@(posedge clk);
			if (refreshActive === lvl)
			begin
				got = 1'b1;
				break;
			end
		end
	endtask : waitRef
	task test_done;
		$display("compares %0d mismatches %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	// ************************************************
	// main sequence
	// ************************************************
	initial
	begin
		resetn = 1'b0;
		tempHot = 1'b0;
		fixedLatency = 1'b0;
		mon = 1'b0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (6) @(posedge clk);
		rdc(rsc_pkg::CFG_RESET);
		chk(16'(clockComplementSeen), 16'h0000);
		// hot interval code, and writes to it are dropped
		tempHot <= 1'b1;
		repeat (10) @(posedge clk);
		rdc(16'hFFC2);
		wr(16'hFFC1);
		rdc(16'hFFC2);
		tempHot <= 1'b0;
		repeat (10) @(posedge clk);
		// differential clock makes the complement visible
		wr(16'hFF81);
		chk(16'(clockDiffSel), 16'h0001);
		// complement pin toggles, so it must be seen high within a few cycles
		got = 1'b0;
		repeat (10)
		begin
			@(posedge clk);
			got = got | clockComplementSeen;
		end
		chk(16'(got), 16'h0001);
		wr(16'hFFC1);
		chk(16'(clockDiffSel), 16'h0000);
		chk(16'(clockComplementSeen), 16'h0000);
		// every region code read back
		for (int r = 0; r < 8; r++)
		begin
			wr({9'h1FF, 2'b10, 3'(r), 2'b00});
			rdc({9'h1FF, 2'b10, 3'(r), 2'b01});
		end
		// region none: no refresh at all, then full array again
		wr(16'hFFD1);
		repeat (20) @(posedge clk);
		refDuring = 0;
		mon = 1'b1;
		repeat (500) @(posedge clk);
		mon = 1'b0;
		chk(16'(refDuring), 16'h0000);
		wr(16'hFFC1);
		waitRef(1'b1, 450);
		chk(16'(got), 16'h0001);
		// long memory frame blocks the due refresh, which then runs
		waitRef(1'b0, 20);
		repeat (200) @(posedge clk);
		refDuring = 0;
		fork
			i_host.frame(16'h0000, 16'h0000, 125, rd, sm, oeLate);
			begin
				repeat (30) @(posedge clk);
				mon = 1'b1;
			end
		join
		mon = 1'b0;
		chk(16'(refDuring), 16'h0000);
		waitRef(1'b1, 20);
		chk(16'(got), 16'h0001);
		// let the busy level cross into the bus clock before the frame starts
		repeat (4) @(posedge clk);
		i_host.frame(16'hC000, 16'h0000, 0, rd, sm, oeLate);
		chk(16'(sm), 16'h0003);
		chk(16'(oeLate), 16'h0000);
		// fixed latency always high, otherwise low on a quiet write
		fixedLatency <= 1'b1;
		repeat (10) @(posedge clk);
		i_host.frame(16'h4000, 16'hFFC1, 0, rd, sm, oeLate);
		chk(16'(sm), 16'h0003);
		fixedLatency <= 1'b0;
		waitRef(1'b0, 20);
		repeat (10) @(posedge clk);
		i_host.frame(16'h4000, 16'hFFC1, 0, rd, sm, oeLate);
		chk({oeLate, 13'h0000, sm}, 16'h0000);
		repeat (12) @(posedge clk);
		// sleep entry, wake by select pulse
		wr(16'hFFE1);
		chk(16'(retentionSleep), 16'h0001);
		i_host.wake();
		repeat (8) @(posedge clk);
		chk(16'(retentionSleep), 16'h0000);
		rdc(16'hFFC1);
		// sleep ended by reset
		wr(16'hFFE1);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (6) @(posedge clk);
		chk(16'(retentionSleep), 16'h0000);
		rdc(16'hFFC1);
		test_done();
	end
endmodule : rsc_top_tb_top
